/* File: design/gpcfg_event_detect.sv */
// gpcfg_event_detect: debounce, polarity and edge or level detection.
// assumes raw pin inputs are asynchronous and settings come on clk.
`timescale 1ns/1ns
`default_nettype none
module gpcfg_event_detect #(
  parameter int unsigned DBNC_CYCLES = gpcfg_pkg::DBNC_CYCLES,
  parameter int unsigned CNT_W       = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // raw event pins
  input  wire logic [15:0]   pin_in,
  // settings and hits
  gpcfg_evt_if.det_side      evt
);
  typedef struct packed {
    logic [15:0]            s1;
    logic [15:0]            s2;
    logic [15:0]            filt;
    logic [15:0]            prev;
    logic [15:0]            hit;
    logic [15:0][CNT_W-1:0] cnt;
  } gpcfg_det_t;

  gpcfg_det_t q_r;
  gpcfg_det_t q_nxt;

  // per pin filter; a change must hold for the whole interval
  always_comb begin
    logic act;
    act   = 1'b0;
    q_nxt = q_r;
    q_nxt.s1 = pin_in;
    q_nxt.s2 = q_r.s1;
    for (int i = 0; i < 16; i++) begin
      if (!evt.dbnc_en[i]) begin
        q_nxt.filt[i] = q_r.s2[i];
        q_nxt.cnt[i]  = '0;
      end else if (q_r.s2[i] == q_r.filt[i]) begin
        q_nxt.cnt[i] = '0;
      end else if (q_r.cnt[i] == CNT_W'(DBNC_CYCLES - 1)) begin
        q_nxt.filt[i] = q_r.s2[i];
        q_nxt.cnt[i]  = '0;
      end else begin
        q_nxt.cnt[i] = q_r.cnt[i] + CNT_W'(1);
      end
      act = evt.polarity[i] ? q_r.filt[i] : ~q_r.filt[i];
      q_nxt.prev[i] = act;
      q_nxt.hit[i]  = evt.level_sel[i] ? act : (act & ~q_r.prev[i]);
    end
  end

  // reset image: pins idle high under the default falling polarity, so the
  // filter starts high and prev inactive; no false edge follows reset
  localparam gpcfg_det_t DET_RST = '{s1: '1, s2: '1, filt: '1, prev: '0, hit: '0, cnt: '0};

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) q_r <= DET_RST;
    else q_r <= q_nxt;
  end

  assign evt.hit = q_r.hit;
endmodule
`default_nettype wire

/* File: design/gpcfg_evt_if.sv */
// gpcfg_evt_if: carries event settings to the detector and hits back.
// assumes both ends share the block clock.
`timescale 1ns/1ns
`default_nettype none
interface gpcfg_evt_if;
  logic [15:0] dbnc_en;
  logic [15:0] polarity;
  logic [15:0] level_sel;
  logic [15:0] hit;
  modport cfg_side (output dbnc_en, output polarity, output level_sel, input hit);
  modport det_side (input dbnc_en, input polarity, input level_sel, output hit);
endinterface
`default_nettype wire

/* File: design/gpcfg_pkg.sv */
// gpcfg_pkg: constants and helpers for the gpio pin configuration block.
// assumes a single 10 MHz clock and that slots are addressed as {port, pin}.
package gpcfg_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_SLOTS = 56;
  localparam int unsigned NUM_EVT   = 16;
  localparam int unsigned CFG_W     = 7;

  // ---------------------------------------------------------------
  // configuration indices and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_PIN_SELECT  = 8'hF0;
  localparam logic [7:0] IDX_PIN_CFG_ONE = 8'hF1;
  localparam int unsigned SEL_PORT_LSB = 4;
  localparam int unsigned SEL_PIN_LSB  = 0;
  localparam int unsigned BIT_DBNC = 6;
  localparam int unsigned BIT_POL  = 5;
  localparam int unsigned BIT_LVL  = 4;
  localparam int unsigned BIT_LOCK = 3;
  localparam int unsigned BIT_PULL = 2;
  localparam int unsigned BIT_PP   = 1;
  localparam int unsigned BIT_OE   = 0;

  // ---------------------------------------------------------------
  // ports with special shape
  // ---------------------------------------------------------------
  localparam logic [2:0] PORT_EVT_A    = 3'h1;
  localparam logic [2:0] PORT_EVT_B    = 3'h4;
  localparam logic [2:0] PORT_SIX_PIN  = 3'h5;
  localparam logic [2:0] PORT_FIVE_PIN = 3'h6;
  localparam logic [2:0] SIX_PINS      = 3'h6;
  localparam logic [2:0] FIVE_PINS     = 3'h5;
  localparam logic [2:0] NO_PORT       = 3'h7;
  localparam logic [5:0] PIN64_SLOT    = 6'h34;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [5:0]  SEL_RST        = 6'h00;
  localparam logic [6:0]  CFG_RST_EVT    = 7'h40;
  localparam logic [6:0]  CFG_RST_PLAIN  = 7'h00;
  localparam logic [55:0] PULLUP_RST_MAP = 56'h100E07FFC30000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DBNC_TIME_NS  = 16000;
  localparam int unsigned DBNC_CYCLES   = (DBNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // slot holds a real pin
  function automatic logic slot_exists(input logic [5:0] slot);
    logic [2:0] port;
    logic [2:0] pin;
    port = slot[5:3];
    pin  = slot[2:0];
    if (port == NO_PORT) return 1'b0;
    else if (port == PORT_SIX_PIN) return pin < SIX_PINS;
    else if (port == PORT_FIVE_PIN) return pin < FIVE_PINS;
    else return 1'b1;
  endfunction

  // slot belongs to a port with event detection
  function automatic logic slot_is_evt(input logic [5:0] slot);
    return (slot[5:3] == PORT_EVT_A) || (slot[5:3] == PORT_EVT_B);
  endfunction

endpackage

/* File: design/gpcfg_sync2.sv */
// gpcfg_sync2: two flop synchroniser for one level from outside the clock.
// assumes the level is held far longer than two clock periods.
`timescale 1ns/1ns
`default_nettype none
module gpcfg_sync2 (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // level
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } gpcfg_sync_t;

  gpcfg_sync_t q_r;
  gpcfg_sync_t q_nxt;

  // first stage is read only by the second
  always_comb begin
    q_nxt    = q_r;
    q_nxt.s1 = async_in;
    q_nxt.s2 = q_r.s1;
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) q_r <= '0;
    else q_r <= q_nxt;
  end

  assign sync_out = q_r.s2;
endmodule
`default_nettype wire

/* File: design/gpcfg_top.sv */
// gpcfg_top: per pin configuration store reached through select and data indices.
// assumes a configuration index port on clk; main reset arrives from a pin.
//
// Summary of operation
// - non-event ports hold bits 7-4 as reserved zero
// - bit 6 on event ports enables debounce of the event input, resets on
// - bit 5 selects event polarity, 0 falling or low, 1 rising or high
// - bit 4 selects edge (0) or level (1) event input
// - bit 3 write-one-sets lock; blocks bits 3-0, second register, data out
// - lock clears on main reset or standby reset per lock reset select
// - global unlock from the lock control register clears every lock but one set by a same-cycle write-one
// - bit 2 drives pull-up enable; read-only while locked
// - bit 1 selects push-pull (1) or open-drain (0); read-only while locked
// - bit 0 enables the output driver; read-only while locked
// - pull-up resets on for listed pins, off for all others
// - pin 64 pull-up held off while standby reset is asserted
// - config register accesses the pin chosen by the pin select register
// - event port pins reset with debounce on, pull-up on for listed pins (slots 32-34), other bits zero
`timescale 1ns/1ns
`default_nettype none
module gpcfg_top #(
  parameter int unsigned DBNC_CYCLES = gpcfg_pkg::DBNC_CYCLES
) (
  // clock and standby reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // configuration index port
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  output logic      [7:0]  cfg_rdata_r,
  output logic             cfg_rvalid_r,
  // lock control
  input  wire logic        main_rst_in,
  input  wire logic        lock_reset_select,
  input  wire logic        global_unlock,
  // event pins
  input  wire logic [15:0] evt_pin_in,
  output logic      [15:0] event_hit_r,
  // per pin controls
  output logic      [55:0] pullup_en_r,
  output logic      [55:0] push_pull_sel_r,
  output logic      [55:0] output_drive_en_r,
  output logic      [55:0] pin_lock_r,
  output logic             sel_locked_r
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0]                                           sel;
    logic [gpcfg_pkg::NUM_SLOTS-1:0][gpcfg_pkg::CFG_W-1:0] cfg;
    logic [55:0]                                          pull;
    logic [7:0]                                           rdata;
    logic                                                 rvalid;
    logic                                                 sel_locked;
  } gpcfg_state_t;

  // reset image of the whole store
  function automatic gpcfg_state_t rst_state();
    gpcfg_state_t s;
    s = '0;
    s.sel = gpcfg_pkg::SEL_RST;
    for (int i = 0; i < gpcfg_pkg::NUM_SLOTS; i++) begin
      if (gpcfg_pkg::slot_is_evt(6'(i))) s.cfg[i] = gpcfg_pkg::CFG_RST_EVT;
      else s.cfg[i] = gpcfg_pkg::CFG_RST_PLAIN;
      s.cfg[i][gpcfg_pkg::BIT_PULL] = gpcfg_pkg::PULLUP_RST_MAP[i];
    end
    s.pull = gpcfg_pkg::PULLUP_RST_MAP;
    s.pull[gpcfg_pkg::PIN64_SLOT] = 1'b0;
    return s;
  endfunction

  localparam gpcfg_state_t ST_RST = rst_state();

  gpcfg_state_t q_r;
  gpcfg_state_t q_nxt;
  logic         main_rst_sync;
  logic [5:0]   cur_slot;
  logic         cur_exists;
  logic         cur_evt;
  logic [55:0]  lock_vec;
  logic [55:0]  pull_vec;

  gpcfg_evt_if evt_bus ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // selected slot decode, shared by read, write and assertions
  assign cur_slot   = q_r.sel;
  assign cur_exists = gpcfg_pkg::slot_exists(cur_slot);
  assign cur_evt    = gpcfg_pkg::slot_is_evt(cur_slot);

  // flattened views of lock and pull-up bits
  always_comb begin
    lock_vec = '0;
    pull_vec = '0;
    for (int i = 0; i < gpcfg_pkg::NUM_SLOTS; i++) begin
      lock_vec[i] = q_r.cfg[i][gpcfg_pkg::BIT_LOCK];
      pull_vec[i] = q_r.cfg[i][gpcfg_pkg::BIT_PULL];
    end
  end

  // main reset comes from another power domain pin
  gpcfg_sync2 u_main_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (main_rst_in),
    .sync_out (main_rst_sync)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [5:0] nslot;
    nslot  = '0;
    q_nxt  = q_r;
    q_nxt.rvalid = 1'b0;
    // lock clearing first, so a same-cycle write-one still sets the lock
    for (int i = 0; i < gpcfg_pkg::NUM_SLOTS; i++) begin
      if (global_unlock) q_nxt.cfg[i][gpcfg_pkg::BIT_LOCK] = 1'b0;
      if (main_rst_sync && !lock_reset_select) begin
        q_nxt.cfg[i][gpcfg_pkg::BIT_LOCK] = 1'b0;
      end
    end
    // index decode for writes
    if (cfg_wr) begin
      if (cfg_addr == gpcfg_pkg::IDX_PIN_SELECT) begin
        q_nxt.sel = {cfg_wdata[gpcfg_pkg::SEL_PORT_LSB +: 3],
                     cfg_wdata[gpcfg_pkg::SEL_PIN_LSB +: 3]};
      end else if (cfg_addr == gpcfg_pkg::IDX_PIN_CFG_ONE && cur_exists) begin
        // event fields stay writable under lock; reserved elsewhere
        if (cur_evt) begin
          q_nxt.cfg[cur_slot][gpcfg_pkg::BIT_DBNC] = cfg_wdata[gpcfg_pkg::BIT_DBNC];
          q_nxt.cfg[cur_slot][gpcfg_pkg::BIT_POL]  = cfg_wdata[gpcfg_pkg::BIT_POL];
          q_nxt.cfg[cur_slot][gpcfg_pkg::BIT_LVL]  = cfg_wdata[gpcfg_pkg::BIT_LVL];
        end
        if (!q_r.cfg[cur_slot][gpcfg_pkg::BIT_LOCK]) begin
          q_nxt.cfg[cur_slot][gpcfg_pkg::BIT_PULL] = cfg_wdata[gpcfg_pkg::BIT_PULL];
          q_nxt.cfg[cur_slot][gpcfg_pkg::BIT_PP]   = cfg_wdata[gpcfg_pkg::BIT_PP];
          q_nxt.cfg[cur_slot][gpcfg_pkg::BIT_OE]   = cfg_wdata[gpcfg_pkg::BIT_OE];
        end
        if (cfg_wdata[gpcfg_pkg::BIT_LOCK]) begin
          q_nxt.cfg[cur_slot][gpcfg_pkg::BIT_LOCK] = 1'b1;
        end
      end
    end
    // index decode for reads; reserved and absent bits give zero
    if (cfg_rd) begin
      q_nxt.rvalid = 1'b1;
      if (cfg_addr == gpcfg_pkg::IDX_PIN_SELECT) begin
        q_nxt.rdata = {1'b0, q_r.sel[5:3], 1'b0, q_r.sel[2:0]};
      end else if (cfg_addr == gpcfg_pkg::IDX_PIN_CFG_ONE && cur_exists) begin
        q_nxt.rdata = {1'b0, cur_evt ? q_r.cfg[cur_slot][6:4] : 3'h0,
                       q_r.cfg[cur_slot][3:0]};
      end else begin
        q_nxt.rdata = 8'h00;
      end
    end
    // pull-up output follows the store without lag
    for (int i = 0; i < gpcfg_pkg::NUM_SLOTS; i++) begin
      q_nxt.pull[i] = q_nxt.cfg[i][gpcfg_pkg::BIT_PULL];
    end
    // lock of the newly selected pin, for the second register and data out
    nslot = q_nxt.sel;
    // absent slots (port 7 and the short ports) have no lock to report
    if (gpcfg_pkg::slot_exists(nslot)) begin
      q_nxt.sel_locked = q_nxt.cfg[nslot][gpcfg_pkg::BIT_LOCK];
    end else begin
      q_nxt.sel_locked = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // standby reset loads the image, which holds the pin 64 pull-up off
  always_ff @(posedge clk) begin
    if (sys_rst) q_r <= ST_RST;
    else q_r <= q_nxt;
  end

  // ---------------------------------------------------------------
  // event path
  // ---------------------------------------------------------------
  // event ports occupy slots 8-15 and 32-39
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      evt_bus.dbnc_en[i]     = q_r.cfg[8 + i][gpcfg_pkg::BIT_DBNC];
      evt_bus.dbnc_en[8 + i] = q_r.cfg[32 + i][gpcfg_pkg::BIT_DBNC];
      evt_bus.polarity[i]     = q_r.cfg[8 + i][gpcfg_pkg::BIT_POL];
      evt_bus.polarity[8 + i] = q_r.cfg[32 + i][gpcfg_pkg::BIT_POL];
      evt_bus.level_sel[i]     = q_r.cfg[8 + i][gpcfg_pkg::BIT_LVL];
      evt_bus.level_sel[8 + i] = q_r.cfg[32 + i][gpcfg_pkg::BIT_LVL];
    end
  end

  gpcfg_event_detect #(
    .DBNC_CYCLES (DBNC_CYCLES),
    .CNT_W       (16)
  ) u_detect (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  (evt_pin_in),
    .evt     (evt_bus.det_side)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    push_pull_sel_r   = '0;
    output_drive_en_r = '0;
    for (int i = 0; i < gpcfg_pkg::NUM_SLOTS; i++) begin
      push_pull_sel_r[i]   = q_r.cfg[i][gpcfg_pkg::BIT_PP];
      output_drive_en_r[i] = q_r.cfg[i][gpcfg_pkg::BIT_OE];
    end
  end

  assign pin_lock_r   = lock_vec;
  assign pullup_en_r  = q_r.pull;
  assign cfg_rdata_r  = q_r.rdata;
  assign cfg_rvalid_r = q_r.rvalid;
  assign sel_locked_r = q_r.sel_locked;
  assign event_hit_r  = evt_bus.hit;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [2:0] cur_low;
  logic [5:0] sel_wr_val;
  assign cur_low    = q_r.cfg[cur_slot][2:0];
  assign sel_wr_val = {cfg_wdata[6:4], cfg_wdata[2:0]};

  property p_sel_write;
    @(posedge clk) disable iff (sys_rst)
    (cfg_wr && cfg_addr == gpcfg_pkg::IDX_PIN_SELECT) |=> (q_r.sel == $past(sel_wr_val));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("pin select not taken");

  property p_lock_blocks;
    @(posedge clk) disable iff (sys_rst)
    (cfg_wr && cfg_addr == gpcfg_pkg::IDX_PIN_CFG_ONE && lock_vec[cur_slot])
      |=> (q_r.cfg[$past(cur_slot)][2:0] == $past(cur_low));
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked bits changed");

  property p_lock_set;
    @(posedge clk) disable iff (sys_rst)
    (cfg_wr && cfg_addr == gpcfg_pkg::IDX_PIN_CFG_ONE && cur_exists && cfg_wdata[3])
      |=> lock_vec[$past(cur_slot)] && sel_locked_r;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set");

  property p_unlock;
    @(posedge clk) disable iff (sys_rst)
    (global_unlock && !cfg_wr) |=> (lock_vec == 56'h0) && !sel_locked_r;
  endproperty
  a_unlock: assert property (p_unlock) else $error("global unlock missed");

  property p_main_clear;
    @(posedge clk) disable iff (sys_rst)
    (main_rst_sync && !lock_reset_select && !cfg_wr) |=> (lock_vec == 56'h0);
  endproperty
  a_main_clear: assert property (p_main_clear) else $error("main reset kept lock");

  property p_rsv_read;
    @(posedge clk) disable iff (sys_rst)
    (cfg_rd && cfg_addr == gpcfg_pkg::IDX_PIN_CFG_ONE && !cur_evt)
      |=> cfg_rvalid_r && (cfg_rdata_r[7:4] == 4'h0);
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("reserved bits not zero");

  property p_reset_pull;
    @(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> (pullup_en_r == ST_RST.pull) && !pullup_en_r[gpcfg_pkg::PIN64_SLOT];
  endproperty
  a_reset_pull: assert property (p_reset_pull) else $error("pull-up reset image wrong");

  property p_reset_evt;
    @(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> (q_r.cfg[8][6:3] == 4'h8) && (q_r.cfg[39][6:3] == 4'h8)
                       && (output_drive_en_r == 56'h0) && (push_pull_sel_r == 56'h0);
  endproperty
  a_reset_evt: assert property (p_reset_evt) else $error("event port reset wrong");

  property p_pull_follows;
    @(posedge clk) disable iff (sys_rst)
    $past(!sys_rst) |-> (pullup_en_r == pull_vec);
  endproperty
  a_pull_follows: assert property (p_pull_follows) else $error("pull-up output stale");

endmodule
`default_nettype wire

/* File: verification/gpcfg_tb_top.sv */
// gpcfg_tb_top: self-checking bench for the pin configuration block.
// assumes gpcfg_top with a short debounce count; inputs move on falling edges.
`timescale 1ns/1ns
`default_nettype none
module gpcfg_tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk;
  logic        sys_rst;
  logic [7:0]  cfg_addr;
  logic [7:0]  cfg_wdata;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [7:0]  cfg_rdata_r;
  logic        cfg_rvalid_r;
  logic        main_rst_in;
  logic        lock_reset_select;
  logic        global_unlock;
  logic [15:0] evt_pin_in;
  logic [15:0] event_hit_r;
  logic [55:0] pullup_en_r;
  logic [55:0] push_pull_sel_r;
  logic [55:0] output_drive_en_r;
  logic [55:0] pin_lock_r;
  logic        sel_locked_r;
  int          failures;
  int          checks;
  logic [7:0]  rv;
  logic [55:0] pmap;
  int          n;
  // sel in the upper byte, expected config byte in the lower
  logic [15:0] rows [10] = '{16'h0000, 16'h1340, 16'h2004, 16'h4440, 16'h6404,
                             16'h5104, 16'h2200, 16'h4740, 16'h3704, 16'hAA00};

  gpcfg_top #(.DBNC_CYCLES(4)) gpcfg_top_i (
    .clk(clk), .sys_rst(sys_rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata_r(cfg_rdata_r),
    .cfg_rvalid_r(cfg_rvalid_r), .main_rst_in(main_rst_in),
    .lock_reset_select(lock_reset_select), .global_unlock(global_unlock),
    .evt_pin_in(evt_pin_in), .event_hit_r(event_hit_r), .pullup_en_r(pullup_en_r),
    .push_pull_sel_r(push_pull_sel_r), .output_drive_en_r(output_drive_en_r),
    .pin_lock_r(pin_lock_r), .sel_locked_r(sel_locked_r));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [55:0] e, input logic [55:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one-cycle strobes; an idle cycle follows so no strobe drops and rises in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_addr = a; cfg_wdata = d; cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cfg_addr = a; cfg_rd = 1'b1;
    @(negedge clk);
    cfg_rd = 1'b0;
    chk("rvalid", 56'h1, {55'h0, cfg_rvalid_r});
    d = cfg_rdata_r;
    @(negedge clk);
    chk("rvalid pulse", 56'h0, {55'h0, cfg_rvalid_r});
  endtask

  task automatic cfg_chk(input logic [7:0] sel, input logic [7:0] e);
    wr(8'hF0, sel);
    rd(8'hF1, rv);
    chk("pin_config_one", {48'h0, e}, {48'h0, rv});
  endtask

  // bounded wait for a hit level; counts cycles taken
  task automatic wait_hit(input int i, input logic v, input int lim, output int c);
    c = 0;
    while (event_hit_r[i] !== v) begin
      @(negedge clk);
      c++;
      if (c > lim) begin
        failures++;
        $display("CHECK FAILED event_hit wait expected %b seen %b", v, event_hit_r[i]);
        test_done();
      end
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    failures = 0; checks = 0;
    sys_rst = 1'b1; cfg_addr = 8'h00; cfg_wdata = 8'h00; cfg_wr = 1'b0; cfg_rd = 1'b0;
    main_rst_in = 1'b0; lock_reset_select = 1'b1; global_unlock = 1'b0;
    evt_pin_in = 16'hFFFF;
    // pull-up map from the listed pin numbers, slot = port*8+pin
    pmap = '0;
    foreach (rows[k]) n = k;
    for (int p = 20; p <= 64; p++)
      if (p inside {20, 21, 26, 27, [30:37], [40:42], [51:53], 64})
        pmap[(p / 10) * 8 + (p % 10)] = 1'b1;
    repeat (4) @(negedge clk);
    chk("pullup in reset", pmap & ~(56'h1 << 52), pullup_en_r);
    sys_rst = 1'b0;
    @(negedge clk);
    chk("pullup after reset", pmap, pullup_en_r);
    chk("lock after reset", 56'h0, pin_lock_r);
    chk("sel_locked", 56'h0, {55'h0, sel_locked_r});
    chk("no hit after reset", 56'h0, {40'h0, event_hit_r});
    // table: select read back and per-slot reset value
    foreach (rows[k]) begin
      cfg_chk(rows[k][15:8], rows[k][7:0]);
      rd(8'hF0, rv);
      chk("pin_select_reg", {48'h0, rows[k][15:8] & 8'h77}, {48'h0, rv});
    end
    $display("test table done");
    // reserved bits and lock on a plain port
    wr(8'hF0, 8'h00);
    wr(8'hF1, 8'hFF);
    cfg_chk(8'h00, 8'h0F);
    chk("outputs slot0", 56'h7, {53'h0, pullup_en_r[0], push_pull_sel_r[0],
        output_drive_en_r[0]});
    chk("sel_locked", 56'h1, {55'h0, sel_locked_r});
    wr(8'hF1, 8'h00);
    cfg_chk(8'h00, 8'h0F);
    // event port fields stay writable under lock
    wr(8'hF0, 8'h10);
    wr(8'hF1, 8'hF7);
    cfg_chk(8'h10, 8'h77);
    wr(8'hF1, 8'h0F);
    wr(8'hF1, 8'h70);
    cfg_chk(8'h10, 8'h7F);
    $display("test lock done");
    // global unlock clears every lock
    global_unlock = 1'b1;
    @(negedge clk);
    global_unlock = 1'b0;
    chk("locks after unlock", 56'h0, pin_lock_r);
    wr(8'hF1, 8'h40);
    cfg_chk(8'h10, 8'h40);
    // main reset: ignored when select is 1, clears when 0
    wr(8'hF0, 8'h00);
    wr(8'hF1, 8'h08);
    main_rst_in = 1'b1;
    repeat (8) @(negedge clk);
    main_rst_in = 1'b0;
    repeat (4) @(negedge clk);
    chk("lock kept", 56'h1, {55'h0, pin_lock_r[0]});
    lock_reset_select = 1'b0;
    main_rst_in = 1'b1;
    repeat (8) @(negedge clk);
    main_rst_in = 1'b0;
    chk("lock cleared", 56'h0, {55'h0, pin_lock_r[0]});
    // unmapped index and absent slot
    wr(8'h30, 8'hFF);
    rd(8'h30, rv);
    chk("unmapped", 56'h0, {48'h0, rv});
    wr(8'hF0, 8'h57);
    wr(8'hF1, 8'hFF);
    cfg_chk(8'h57, 8'h00);
    $display("test reset and unmapped done");
    // falling edge with debounce on slot 9
    repeat (10) @(negedge clk);
    evt_pin_in[1] = 1'b0;
    wait_hit(1, 1'b1, 20, n);
    chk("debounce delay", 56'(2 + 4 + 1), 56'(n));
    @(negedge clk);
    chk("edge pulse", 56'h0, {55'h0, event_hit_r[1]});
    // rising level without debounce
    cfg_chk(8'h11, 8'h40);
    wr(8'hF1, 8'h30);
    repeat (8) @(negedge clk);
    chk("level idle", 56'h0, {55'h0, event_hit_r[1]});
    evt_pin_in[1] = 1'b1;
    wait_hit(1, 1'b1, 8, n);
    repeat (5) @(negedge clk);
    chk("level held", 56'h1, {55'h0, event_hit_r[1]});
    evt_pin_in[1] = 1'b0;
    wait_hit(1, 1'b0, 8, n);
    $display("test events done");
    // second standby reset mid run restores defaults and drops a set lock
    wr(8'hF0, 8'h00);
    wr(8'hF1, 8'h08);
    chk("lock before reset", 56'h1, {55'h0, pin_lock_r[0]});
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    cfg_chk(8'h11, 8'h40);
    cfg_chk(8'h00, 8'h00);
    $display("test rerun reset done");
    test_done();
  end
endmodule
`default_nettype wire
